// ==== rtl/mrst_unit.sv ====
// Purpose: MCU reset recognition, pulse qualification and initial-value loading
// Assumes: reset pin slow enough for a two-stage synchroniser; events already synchronous to aclk
// Notes: State words are software visible over AXI4-Lite
//
// Design decisions made here: the AXI4-Lite slave port and the address map.
`default_nettype none
// Functional notes
// [RULE1] Low pin holds reset; high releases it
// [RULE2] Source holds pin low one settle time
// [RULE3] Running reset lasts at least two instructions
// [RULE4] Counter zero, status one, stack 3FF
// [RULE5] Interrupt enable and requests cleared
// [RULE6] All interrupt masks set
// [RULE7] Port output data all ones
// [RULE8] Port direction all zero
// [RULE9] Port mode A, B, C bits cleared; code keeps port mode C bit 2 and clears C bits 3, 1, 0
// [RULE10] Both edge select registers cleared
// [RULE11] All timer mode registers cleared
// [RULE12] Serial mode A cleared, B low bit
// [RULE13] Reload low nibbles cleared, upper kept
// [RULE14] ADC mode cleared, result 80 hex
// [RULE15] LCD control and duty registers cleared
// [RULE16] LCD segment select bits cleared
// [RULE17] Low speed and direct transfer cleared
// [RULE18] Watchdog enable cleared
// [RULE19] ADC start and current-off cleared
// [RULE20] Capture status and error cleared
// [RULE21] Misc cleared, clock select bits 2,1
// [RULE22] RAM bank select cleared
// [RULE23] Pin synchronised before qualification and loading
module mrst_unit
  import mrst_pkg::*;
#(
  parameter int SETTLE_CYC = SETTLE_MIN_CYC,
  parameter int CNT_W = 24
)
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic reset_pin_n,
  input wire logic stop_mode,
  input wire logic [9:0] irq_event,
  output logic mcu_rst,
  output mrst_state_t state,
  input wire logic [5:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [5:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  // ==========================================================
  // Decode helpers
  function automatic logic addr_ok(input logic [5:0] a);
    addr_ok = (a[1:0] == 2'h0) && (int'(a[5:2]) < NWORD);
  endfunction : addr_ok

  function automatic logic [31:0] strb_mask(input logic [3:0] s);
    strb_mask = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
  endfunction : strb_mask

  logic [31:0] word [1:NWORD-1];
  logic [31:0] view [NWORD];
  logic pin_s1;
  logic pin_s2;
  logic [CNT_W-1:0] low_cnt;
  logic por_pending;
  logic run_err;
  logic settle_err;
  logic release_now;
  logic need_settle;
  logic short_pulse;
  logic aw_hold;
  logic w_hold;
  logic [5:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic wr_go;
  logic [3:0] wr_idx;
  logic [31:0] wr_mask;

  // ==========================================================
  // Reset pin synchroniser and qualification
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pin_s1 <= 1'b0;
      pin_s2 <= 1'b0;
    end
    else
    begin
      pin_s1 <= reset_pin_n; // [RULE23]
      pin_s2 <= pin_s1;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      mcu_rst <= 1'b1;
    else
      mcu_rst <= ~pin_s2; // [RULE1]
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn || pin_s2)
      low_cnt <= '0;
    else if (low_cnt != {CNT_W{1'b1}})
      low_cnt <= low_cnt + 1'b1;
  end

  assign release_now = pin_s2 && mcu_rst;
  assign need_settle = por_pending || stop_mode;
  assign short_pulse = need_settle ? (int'(low_cnt) < SETTLE_CYC) : (int'(low_cnt) < RUN_MIN_CYC);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      por_pending <= 1'b1;
    else if (release_now)
      por_pending <= 1'b0;
  end

  // Violation flags: set wins over a same-cycle write-one clear
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      run_err <= 1'b0;
      settle_err <= 1'b0;
    end
    else
    begin
      if (release_now && short_pulse && !need_settle)
        run_err <= 1'b1; // [RULE3]
      else if (wr_go && wr_idx == 4'(IDX_STATUS) && wr_mask[1] && w_data[1])
        run_err <= 1'b0;
      if (release_now && short_pulse && need_settle)
        settle_err <= 1'b1; // [RULE2]
      else if (wr_go && wr_idx == 4'(IDX_STATUS) && wr_mask[2] && w_data[2])
        settle_err <= 1'b0;
    end
  end

  // ==========================================================
  // Initial-value state words
  // [RULE4] [RULE5] [RULE6] [RULE7] [RULE8] [RULE9] [RULE10] [RULE11] [RULE12] [RULE13] [RULE14]
  // [RULE15] [RULE16] [RULE17] [RULE18] [RULE19] [RULE20] [RULE21] [RULE22] loaded below
  // Read view: word 0 is the live status, the rest are the stored words
  always_comb
  begin
    view[0] = {28'h0, por_pending, settle_err, run_err, mcu_rst};
    for (int k = 1; k < NWORD; k++)
      view[k] = word[k];
  end

  for (genvar i = 1; i < NWORD; i++)
  begin : g_word
    always_ff @(posedge aclk)
    begin
      if (!aresetn)
        word[i] <= RST_VAL[i];
      else if (mcu_rst)
        word[i] <= (word[i] & ~RST_MASK[i]) | RST_VAL[i];
      else if (i == IDX_IRQ)
      begin
        // Requests clear only by writing zero; hardware events win
        if (wr_go && wr_idx == 4'(i))
          word[i] <= ((word[i] & ~wr_mask) | (w_data & wr_mask & ~IRQ_REQ_BITS)
            | (word[i] & w_data & wr_mask & IRQ_REQ_BITS)) | {18'h0, irq_event, 4'h0};
        else
          word[i] <= word[i] | {18'h0, irq_event, 4'h0};
      end
      else if (wr_go && wr_idx == 4'(i))
        word[i] <= (word[i] & ~wr_mask) | (w_data & wr_mask);
    end
  end

  assign state = {word[9], word[8], word[7], word[6], word[5], word[4], word[3], word[2], word[1]};

  // ==========================================================
  // AXI4-Lite write channel
  assign s_axi_awready = ~aw_hold;
  assign s_axi_wready = ~w_hold;
  assign wr_go = aw_hold && w_hold && !s_axi_bvalid;
  assign wr_idx = aw_addr[5:2];
  assign wr_mask = addr_ok(aw_addr) ? strb_mask(w_strb) & IMPL[wr_idx] : 32'h0;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_hold <= 1'b0;
      aw_addr <= 6'h00;
    end
    else if (s_axi_awvalid && !aw_hold)
    begin
      aw_hold <= 1'b1;
      aw_addr <= s_axi_awaddr;
    end
    else if (wr_go)
      aw_hold <= 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      w_hold <= 1'b0;
      w_data <= 32'h0;
      w_strb <= 4'h0;
    end
    else if (s_axi_wvalid && !w_hold)
    begin
      w_hold <= 1'b1;
      w_data <= s_axi_wdata;
      w_strb <= s_axi_wstrb;
    end
    else if (wr_go)
      w_hold <= 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end
    else if (wr_go)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= addr_ok(aw_addr) ? RESP_OKAY : RESP_SLVERR;
    end
    else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end

  // ==========================================================
  // AXI4-Lite read channel
  assign s_axi_arready = ~s_axi_rvalid;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= RESP_OKAY;
    end
    else if (s_axi_arvalid && !s_axi_rvalid)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= addr_ok(s_axi_araddr) ? view[s_axi_araddr[5:2]] & IMPL[s_axi_araddr[5:2]] : 32'h0;
      s_axi_rresp <= addr_ok(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  AST_ENTER: assert property (!pin_s2 |=> mcu_rst) // [RULE1]
    else $error("reset not entered while pin low");
  AST_LEAVE: assert property (mcu_rst && pin_s2 ##1 pin_s2 |-> !mcu_rst) // [RULE1]
    else $error("reset not left after pin high");
  AST_SYNC: assert property ($fell(reset_pin_n) |-> ##3 mcu_rst) // [RULE23]
    else $error("synchronised reset latency wrong");
  AST_SETTLE: assert property (release_now && need_settle && int'(low_cnt) < SETTLE_CYC
    |=> settle_err) // [RULE2]
    else $error("short settle pulse not flagged");
  AST_RUN: assert property (release_now && !need_settle && int'(low_cnt) < RUN_MIN_CYC
    |=> run_err) // [RULE3]
    else $error("short running pulse not flagged");
  AST_CORE: assert property ($past(mcu_rst) |-> state.core.program_counter == 14'h0000
    && state.core.branch_status_flag && state.core.stack_pointer == 10'h3FF) // [RULE4]
    else $error("core initial values wrong");
  AST_IRQEN: assert property (mcu_rst |=> !state.irq.global_irq_enable
    && state.irq.irq_req == 10'h000) // [RULE5]
    else $error("interrupt enable or request not cleared");
  AST_MASK: assert property (mcu_rst |=> state.irq.irq_mask_bit == 10'h3FF) // [RULE6]
    else $error("interrupt masks not set");
  AST_PDATA: assert property (mcu_rst |=> &state.port_out_data) // [RULE7]
    else $error("port data not all ones");
  AST_PDIR: assert property (mcu_rst |=> state.port_dir == 32'h0000_0000) // [RULE8]
    else $error("port direction not cleared");
  AST_PMODE: assert property (mcu_rst |=> state.pmode.port_mode_a == 2'h0
    && state.pmode.port_mode_b == 3'h0 && (state.pmode.port_mode_c & 4'hB) == 4'h0) // [RULE9]
    else $error("port mode not cleared");
  AST_EDGE: assert property (mcu_rst |=> state.pmode.edge_select_1 == 4'h0
    && state.pmode.edge_select_2 == 2'h0) // [RULE10]
    else $error("edge select not cleared");
  AST_TIMER: assert property (mcu_rst |=> (word[6] & IMPL[6]) == 32'h0) // [RULE11]
    else $error("timer modes not cleared");
  AST_RELOAD: assert property (mcu_rst |=> state.ser.timer_b_reload[3:0] == 4'h0
    && state.ser.timer_c_reload[3:0] == 4'h0 && state.ser.timer_d_reload[3:0] == 4'h0
    && state.ser.timer_b_reload[7:4] == $past(state.ser.timer_b_reload[7:4])) // [RULE13]
    else $error("reload low nibble wrong");
  AST_ADC: assert property (mcu_rst |=> state.adlcd.adc_result == 8'h80
    && state.adlcd.adc_mode == 4'h0) // [RULE14]
    else $error("adc reset values wrong");
  AST_BITS: assert property (mcu_rst |=> (word[9] & IMPL[9]) == 32'h0) // [RULE22]
    else $error("bit flags not cleared");
  AST_PORTC: assert property (mcu_rst |=> state.pmode.port_mode_c[2] == $past(state.pmode.port_mode_c[2])) // [RULE9]
    else $error("port mode C bit 2 not kept");
  AST_SERIAL: assert property (mcu_rst |=> state.ser.serial_mode_a == 4'h0
    && !state.ser.serial_mode_b[0]) // [RULE12]
    else $error("serial modes not cleared");
  AST_LCD: assert property (mcu_rst |=> state.adlcd.lcd_control == 4'h0 && state.adlcd.lcd_duty_clock == 4'h0) // [RULE15]
    else $error("lcd control not cleared");
  AST_SEG: assert property (mcu_rst |=> state.adlcd.lcd_seg_select3[2:1] == 2'h0) // [RULE16]
    else $error("lcd segment select not cleared");
  AST_MODEFLAG: assert property (mcu_rst |=> !state.bits.low_speed_on && !state.bits.direct_transfer_on) // [RULE17]
    else $error("operating mode flags not cleared");
  AST_WDOG: assert property (mcu_rst |=> !state.bits.watchdog_on) // [RULE18]
    else $error("watchdog enable not cleared");
  AST_ADCFLAG: assert property (mcu_rst |=> !state.bits.adc_start_flag && !state.bits.adc_current_off) // [RULE19]
    else $error("adc flags not cleared");
  AST_CAPT: assert property (mcu_rst |=> !state.bits.capture_status_flag && !state.bits.capture_error_flag) // [RULE20]
    else $error("capture flags not cleared");
  AST_MISC: assert property (mcu_rst |=> state.bits.misc_control == 4'h0
    && state.bits.sysclk_select[2:1] == 2'h0) // [RULE21]
    else $error("misc or clock select not cleared");
  AST_IRQSET: assert property (!mcu_rst && irq_event != 10'h000
    |=> (state.irq.irq_req & $past(irq_event)) == $past(irq_event)) // [RULE5]
    else $error("interrupt event not recorded");
endmodule : mrst_unit
`default_nettype wire

// ==== rtl/mrst_pkg.sv ====
// Purpose: Shared constants and types of the MCU reset and initial-value unit
// Assumes: 50 MHz aclk, 32-bit AXI4-Lite register words
// Notes: Word layouts are packed structs, LSB last
`default_nettype none
package mrst_pkg;
  localparam int CLK_NS = 20;
  localparam int INSTR_CYCLE_NS = 1000;
  localparam int OSC_SETTLE_NS = 1000000;
  localparam int RUN_MIN_CYC = (2 * INSTR_CYCLE_NS + CLK_NS - 1) / CLK_NS;
  localparam int SETTLE_MIN_CYC = (OSC_SETTLE_NS + CLK_NS - 1) / CLK_NS;
  localparam int NWORD = 10;
  localparam int IDX_STATUS = 0;
  localparam int IDX_IRQ = 2;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [31:0] ST_W1C = 32'h0000_0006;
  localparam logic [31:0] IRQ_REQ_BITS = 32'h0000_3FF0;
  // Byte offsets are 4 * index; index 0 is the status word
  localparam logic [31:0] IMPL [NWORD] = '{32'h0000_000F, 32'h03FF_7FFF, 32'h3FF0_3FF1,
    32'hFFFF_FFFF, 32'hFFFF_FFFF, 32'h0003_FF73, 32'h0FF7_F3FF, 32'hFFFF_FF3F,
    32'h06FF_FF0F, 32'h0001_6F7F};
  // Bits forced on MCU reset; others keep their value
  localparam logic [31:0] RST_MASK [NWORD] = '{32'h0, 32'h03FF_7FFF, 32'h3FF0_3FF1,
    32'hFFFF_FFFF, 32'hFFFF_FFFF, 32'h0003_FB73, 32'h0FF7_F3FF, 32'h0F0F_0F1F,
    32'h06FF_FF0F, 32'h0001_6F7F};
  localparam logic [31:0] RST_VAL [NWORD] = '{32'h0, 32'h03FF_4000, 32'h3FF0_0000,
    32'hFFFF_FFFF, 32'h0000_0000, 32'h0, 32'h0, 32'h0, 32'h0000_8000, 32'h0};
  typedef struct packed {
    logic [5:0] rsv_h; logic [9:0] stack_pointer; logic rsv_m;
    logic branch_status_flag; logic [13:0] program_counter;
  } mrst_core_t;
  typedef struct packed {
    logic [1:0] rsv_h; logic [9:0] irq_mask_bit; logic [5:0] rsv_m;
    logic [9:0] irq_req; logic [2:0] rsv_l; logic global_irq_enable;
  } mrst_irq_t;
  typedef struct packed {
    logic [13:0] rsv_h; logic [1:0] edge_select_2; logic [3:0] edge_select_1;
    logic [3:0] port_mode_c; logic rsv_m; logic [2:0] port_mode_b; logic [1:0] rsv_l;
    logic [1:0] port_mode_a;
  } mrst_pmode_t;
  typedef struct packed {
    logic [3:0] rsv_h; logic [3:0] timer_d_mode2; logic [3:0] timer_d_mode1; logic rsv_c;
    logic [2:0] timer_c_mode2; logic [3:0] timer_c_mode1; logic [1:0] rsv_b;
    logic [1:0] timer_b_mode2; logic [3:0] timer_b_mode1; logic [3:0] timer_a_mode;
  } mrst_tmode_t;
  typedef struct packed {
    logic [7:0] timer_d_reload; logic [7:0] timer_c_reload; logic [7:0] timer_b_reload;
    logic [1:0] rsv; logic [1:0] serial_mode_b; logic [3:0] serial_mode_a;
  } mrst_ser_t;
  typedef struct packed {
    logic [3:0] rsv_h; logic [3:0] lcd_seg_select3; logic [3:0] lcd_duty_clock;
    logic [3:0] lcd_control; logic [7:0] adc_result; logic [3:0] rsv_l; logic [3:0] adc_mode;
  } mrst_adlcd_t;
  typedef struct packed {
    logic [14:0] rsv_h; logic ram_bank; logic rsv_s; logic [2:0] sysclk_select; logic [3:0] misc_control;
    logic rsv_l; logic capture_error_flag; logic capture_status_flag; logic adc_current_off;
    logic adc_start_flag; logic watchdog_on; logic direct_transfer_on; logic low_speed_on;
  } mrst_bits_t;
  typedef struct packed {
    mrst_bits_t bits; mrst_adlcd_t adlcd; mrst_ser_t ser; mrst_tmode_t tmode;
    mrst_pmode_t pmode; logic [31:0] port_dir; logic [31:0] port_out_data;
    mrst_irq_t irq; mrst_core_t core;
  } mrst_state_t;
endpackage : mrst_pkg
`default_nettype wire

// ==== sim/mrst_pin_src.sv ====
// Purpose: External reset source model that drives the MCU reset pin
// Assumes: Called right after a rising aclk edge
// Notes: The caller picks the low time, short or long
`default_nettype none
module mrst_pin_src
(
  input wire logic aclk,
  output logic reset_pin_n
);
  timeunit 1ns;
  timeprecision 1ns;
  initial reset_pin_n = 1'h1;
  // ==========
  // Pin pulse
  task automatic pulse_low(input int cycles);
    reset_pin_n <= 1'h0;
    repeat (cycles) @(posedge aclk);
    reset_pin_n <= 1'h1;
  endtask : pulse_low
endmodule : mrst_pin_src
`default_nettype wire

// ==== sim/mrst_unit_test.sv ====
// Purpose: Self-checking bench of the MCU reset and initial-value unit
// Assumes: AXI4-Lite master tasks, pin driven by the source model
// Notes: Settle time shortened to 20 cycles
`default_nettype none
module mrst_unit_test
  import mrst_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int SETTLE = 20;
  logic aclk = 1'h0, aresetn = 1'h0, stop_mode = 1'h0;
  logic [9:0] irq_event = 10'h000;
  wire logic reset_pin_n;
  logic mcu_rst;
  mrst_state_t state;
  logic [5:0] awaddr = 6'h00, araddr = 6'h00;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic [31:0] wdata = 32'h0, rdata, d, e;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, r;
  int miscompares = 0, num_checks = 0;
  always #10 aclk = ~aclk;
  mrst_pin_src src (.aclk(aclk), .reset_pin_n(reset_pin_n));
  mrst_unit #(.SETTLE_CYC(SETTLE)) dut (.aclk(aclk), .aresetn(aresetn), .reset_pin_n(reset_pin_n),
    .stop_mode(stop_mode), .irq_event(irq_event), .mcu_rst(mcu_rst), .state(state),
    .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  // ==========
  // Bus tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic axi_wr(input logic [5:0] a, input logic [31:0] v, output logic [1:0] resp);
    logic aw_p, w_p;
    aw_p = 1'h1;
    w_p = 1'h1;
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    while (aw_p || w_p)
    begin
      @(posedge aclk);
      if (awready === 1'h1) aw_p = 1'h0;
      if (wready === 1'h1) w_p = 1'h0;
      awvalid <= aw_p;
      wvalid <= w_p;
    end
    while (bvalid !== 1'h1) @(posedge aclk);
    resp = bresp;
    bready <= 1'h0;
    @(posedge aclk);
  endtask : axi_wr
  task automatic axi_rd(input logic [5:0] a, output logic [31:0] v, output logic [1:0] resp);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do @(posedge aclk); while (arready !== 1'h1);
    arvalid <= 1'h0;
    do @(posedge aclk); while (rvalid !== 1'h1);
    v = rdata;
    resp = rresp;
    rready <= 1'h0;
    @(posedge aclk);
  endtask : axi_rd
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : report_and_stop
  // ==========
  // Tests
  initial
  begin
    #(20 * 5000);
    miscompares++;
    report_and_stop;
  end
  initial
  begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'h1;
    while (mcu_rst !== 1'h0) @(posedge aclk);
    axi_wr(6'h00, 32'h6, r);
    for (int i = 1; i < NWORD; i++)
    begin
      axi_wr(6'(i * 4), 32'hFFFF_FFFF, r);
      chk(r, RESP_OKAY);
    end
    irq_event <= 10'h3FF;
    @(posedge aclk);
    irq_event <= 10'h000;
    repeat (2) @(posedge aclk);
    chk(state.irq.irq_req, 32'h3FF);
    stop_mode <= 1'h1;
    fork
      src.pulse_low(120);
      begin
        @(posedge aclk);
        chk(mcu_rst, 32'h0);
        repeat (4) @(posedge aclk);
        chk(mcu_rst, 32'h1);
        axi_wr(6'h10, 32'hFFFF_FFFF, r);
        chk(r, RESP_OKAY);
        irq_event <= 10'h3FF;
        @(posedge aclk);
        irq_event <= 10'h000;
      end
    join
    while (mcu_rst !== 1'h0) @(posedge aclk);
    stop_mode <= 1'h0;
    chk(state.core.program_counter, 32'h0);
    chk({state.core.stack_pointer, state.core.branch_status_flag}, {10'h3FF, 1'h1});
    chk({state.irq.irq_mask_bit, state.irq.irq_req, state.irq.global_irq_enable}, {10'h3FF, 11'h0});
    chk(state.port_out_data, 32'hFFFF_FFFF);
    chk(state.port_dir, 32'h0);
    chk(state.adlcd.adc_result, 32'h80);
    chk(state.bits & 32'h0001_6F7F, 32'h0);
    for (int i = 1; i < NWORD; i++)
    begin
      axi_rd(6'(i * 4), d, r);
      e = (~RST_MASK[i] | RST_VAL[i]) & IMPL[i];
      chk(d, e);
    end
    axi_rd(6'h00, d, r);
    chk(d & 32'h7, 32'h0);
    src.pulse_low(10);
    while (mcu_rst !== 1'h0) @(posedge aclk);
    axi_rd(6'h00, d, r);
    chk(d & 32'h7, 32'h2);
    stop_mode <= 1'h1;
    src.pulse_low(10);
    while (mcu_rst !== 1'h0) @(posedge aclk);
    stop_mode <= 1'h0;
    axi_rd(6'h00, d, r);
    chk(d & 32'h7, 32'h6);
    axi_wr(6'h00, 32'h6, r);
    axi_rd(6'h00, d, r);
    chk(d & 32'h7, 32'h0);
    axi_rd(6'h28, d, r);
    chk(r, RESP_SLVERR);
    chk(d, 32'h0);
    axi_rd(6'h05, d, r);
    chk(r, RESP_SLVERR);
    axi_wr(6'h28, 32'hFFFF_FFFF, r);
    chk(r, RESP_SLVERR);
    report_and_stop;
  end
endmodule : mrst_unit_test
`default_nettype wire
